/* rtl/acdc_pkg.sv */
// Package for the converter correction and sample DMA block
package acdc_pkg;

	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] REG_CFG      = 8'h00;
	localparam logic [7:0] REG_OFFSET   = 8'h04;
	localparam logic [7:0] REG_GAIN     = 8'h08;
	localparam logic [7:0] REG_DATA     = 8'h0c;
	localparam logic [7:0] REG_FLAG     = 8'h10;
	localparam logic [7:0] REG_MASK     = 8'h14;
	localparam logic [7:0] REG_DMA_CTRL = 8'h18;
	localparam logic [7:0] REG_DMA_BEG  = 8'h1c;
	localparam logic [7:0] REG_DMA_SIZE = 8'h20;
	localparam logic [7:0] REG_DMA_CUR  = 8'h24;

	// Configuration register fields
	localparam int CFG_EN_BIT      = 0;
	localparam int CFG_REFOUT_BIT  = 1;
	localparam int CFG_POS_LSB     = 4;
	localparam int CFG_NEG_LSB     = 8;
	localparam int CFG_WIDTH       = 12;

	// DMA control fields
	localparam int DMA_LOAD_BIT    = 0;
	localparam int DMA_WRAP_BIT    = 1;
	localparam int DMA_RESET_BIT   = 4;

	// Event flag positions
	localparam int FLAG_OVERRUN    = 0;
	localparam int FLAG_SATURATE   = 1;
	localparam int FLAG_FULL       = 2;
	localparam int FLAG_HALF       = 3;
	localparam int FLAG_DATA       = 4;
	localparam int FLAG_WIDTH      = 5;

	// Reset values, saturation limits and gain fraction bits
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] GAIN_RST   = 16'h8000;
	localparam logic [15:0] SAT_MAX    = 16'h7fff;
	localparam logic [15:0] SAT_MIN    = 16'h8000;
	localparam int          GAIN_FRAC  = 15;

	// Pin configuration and input select decode
	localparam logic [3:0] PIN_ANALOG  = 4'h0;
	localparam int         NUM_PINS    = 7;
	localparam int         REF_PIN     = 6;
	localparam int         NUM_SRC     = 12;
	localparam logic [3:0] SEL_EXT_MAX = 4'h5;
	localparam logic [3:0] SEL_GND     = 4'h8;
	localparam logic [3:0] SEL_PAD_HALF = 4'hb;

	// DMA channel states
	typedef enum logic [1:0] {DMA_IDLE, DMA_RUN, DMA_DONE} acdc_dma_state_t;

	// One half-word write toward RAM
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} acdc_ram_wr_t;

endpackage

/* rtl/acdc_top.sv */
// Converter offset and gain correction with sample DMA channel
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module acdc_top (
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_b_in,
	input  wire logic [7:0]             reg_addr_in,
	input  wire logic [31:0]            reg_wdata_in,
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	output logic      [31:0]            reg_rdata_out,
	input  wire logic                   conv_done_in,
	input  wire logic [15:0]            conv_raw_in,
	output logic                        conv_enable_out,
	output logic      [11:0]            pos_source_out,
	output logic      [11:0]            neg_source_out,
	output logic                        vref_drive_out,
	input  wire logic [6:0][3:0]        pin_config_fields_in,
	input  wire logic [6:0]             pin_raw_in,
	output logic      [6:0]             port_input_value_out,
	output logic      [6:0]             pin_digital_en_out,
	output acdc_pkg::acdc_ram_wr_t      ram_wr_out,
	output logic                        ram_req_out,
	input  wire logic                   ram_ready_in,
	output logic                        irq_out
);
	import acdc_pkg::*;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	logic [CFG_WIDTH-1:0]  cfg_r;
	logic [15:0]           offset_r;
	logic [15:0]           gain_r;
	logic [15:0]           result_r;
	logic [FLAG_WIDTH-1:0] flags_r;
	logic [FLAG_WIDTH-1:0] mask_r;
	logic                  wrap_r;
	logic [15:0]           beg_r;
	logic [15:0]           size_r;
	logic [15:0]           cur_r;
	logic [15:0]           count_r;
	acdc_dma_state_t       state_r;
	logic                  pend_r;
	logic [15:0]           corr_nxt;
	logic                  sat_nxt;
	logic                  wr_done;
	logic                  last_sample;
	logic                  half_sample;
	logic                  overrun_evt;
	logic [FLAG_WIDTH-1:0] set_evt;
	logic [FLAG_WIDTH-1:0] clr_mask;
	logic                  load_wr;
	logic                  reset_wr;
	logic [6:0]            pin_analog;

	// Input select decode to a one-hot source vector, all zero for codes 6, 7 and 12 to 15
	function automatic logic [11:0] decode_sel(input logic [3:0] code);
		logic [11:0] src;
		src = '0;
		if (code <= SEL_EXT_MAX) begin
			src[code] = 1'b1;
		end else if (code >= SEL_GND && code <= SEL_PAD_HALF) begin
			src[code - 4'h2] = 1'b1;
		end
		return src;
	endfunction

	// Offset add, gain multiply with clamp, then halving
	function automatic logic [16:0] correct(input logic [15:0] raw,
	                                        input logic [15:0] ofs,
	                                        input logic [15:0] gain);
		logic signed [16:0] sum;
		logic signed [33:0] prod;
		logic signed [33:0] scaled;
		logic        [15:0] clip;
		logic               sat;
		sum    = 17'(signed'(raw)) + 17'(signed'(ofs));
		prod   = 34'(sum) * 34'(signed'({1'b0, gain}));
		scaled = prod >>> GAIN_FRAC;
		sat    = 1'b0;
		clip   = scaled[15:0];
		if (scaled > 34'(signed'(SAT_MAX))) begin
			clip = SAT_MAX;
			sat  = 1'b1;
		end else if (scaled < 34'(signed'(SAT_MIN))) begin
			clip = SAT_MIN;
			sat  = 1'b1;
		end
		return {sat, clip[15], clip[15:1]};
	endfunction

	assign {sat_nxt, corr_nxt} = correct(conv_raw_in, offset_r, gain_r);

	// Source selection and converter enable
	assign conv_enable_out = cfg_r[CFG_EN_BIT];
	assign pos_source_out  = decode_sel(cfg_r[CFG_POS_LSB +: 4]);
	assign neg_source_out  = decode_sel(cfg_r[CFG_NEG_LSB +: 4]);

	// Analog pins are cut off from digital use and read as one
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_analog[i]           = pin_config_fields_in[i] == PIN_ANALOG;
			port_input_value_out[i] = pin_analog[i] | pin_raw_in[i];
			pin_digital_en_out[i]   = ~pin_analog[i];
		end
	end

	// Internal reference reaches its pin only when safe
	assign vref_drive_out = cfg_r[CFG_EN_BIT] & cfg_r[CFG_REFOUT_BIT]
	                      & pin_analog[REF_PIN];

	// Register strobes
	assign load_wr  = reg_wr_in && reg_addr_in == REG_DMA_CTRL
	                && reg_wdata_in[DMA_LOAD_BIT];
	assign reset_wr = reg_wr_in && reg_addr_in == REG_DMA_CTRL
	                && reg_wdata_in[DMA_RESET_BIT];

	// Configuration and correction registers
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			cfg_r    <= '0;
			offset_r <= OFFSET_RST;
			gain_r   <= GAIN_RST;
			mask_r   <= '0;
			beg_r    <= '0;
			size_r   <= '0;
			wrap_r   <= 1'b0;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				REG_CFG:      cfg_r    <= reg_wdata_in[CFG_WIDTH-1:0];
				REG_OFFSET:   offset_r <= reg_wdata_in[15:0];
				REG_GAIN:     gain_r   <= reg_wdata_in[15:0];
				REG_MASK:     mask_r   <= reg_wdata_in[FLAG_WIDTH-1:0];
				REG_DMA_BEG:  beg_r    <= reg_wdata_in[15:0];
				REG_DMA_SIZE: size_r   <= reg_wdata_in[15:0];
				REG_DMA_CTRL: begin
					if (reg_wdata_in[DMA_LOAD_BIT]) begin
						wrap_r <= reg_wdata_in[DMA_WRAP_BIT];
					end
				end
				default: ;
			endcase
		end
	end

	// Latest corrected result
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			result_r <= '0;
		end else if (conv_done_in) begin
			result_r <= corr_nxt;
		end
	end

	// DMA progress terms
	assign wr_done     = ram_req_out & ram_ready_in;
	assign last_sample = count_r + 16'h0001 == size_r;
	assign half_sample = count_r + 16'h0001 == (size_r >> 1);
	assign overrun_evt = conv_done_in && (state_r == DMA_DONE || pend_r);

	// DMA channel: pointer, sample count and state
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_r <= DMA_IDLE;
			cur_r   <= '0;
			count_r <= '0;
		end else if (reset_wr) begin
			state_r <= DMA_IDLE;
			cur_r   <= beg_r;
			count_r <= '0;
		end else if (load_wr) begin
			state_r <= DMA_RUN;
			cur_r   <= beg_r;
			count_r <= '0;
		end else if (wr_done) begin
			if (last_sample) begin
				cur_r   <= beg_r;
				count_r <= '0;
				if (!wrap_r) begin
					state_r <= DMA_DONE;
				end
			end else begin
				cur_r   <= cur_r + 16'h0002;
				count_r <= count_r + 16'h0001;
			end
		end
	end

	// Pending half-word write, held until RAM accepts it
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			pend_r     <= 1'b0;
			ram_wr_out <= '0;
		end else if (reset_wr || load_wr) begin
			pend_r <= 1'b0;
		end else if (conv_done_in && state_r == DMA_RUN && !pend_r) begin
			pend_r          <= 1'b1;
			ram_wr_out.addr <= cur_r;
			ram_wr_out.data <= corr_nxt;
		end else if (wr_done) begin
			pend_r <= 1'b0;
		end
	end

	assign ram_req_out = pend_r && state_r == DMA_RUN;

	// Event sets and write-one clears
	always_comb begin
		set_evt                = '0;
		set_evt[FLAG_DATA]     = conv_done_in;
		set_evt[FLAG_SATURATE] = conv_done_in & sat_nxt;
		set_evt[FLAG_OVERRUN]  = overrun_evt;
		set_evt[FLAG_HALF]     = wr_done & half_sample;
		set_evt[FLAG_FULL]     = wr_done & last_sample;
		clr_mask               = '0;
		if (reg_wr_in && reg_addr_in == REG_FLAG) begin
			clr_mask = reg_wdata_in[FLAG_WIDTH-1:0];
		end
	end

	// Sticky flags; a set in the clearing cycle wins
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			flags_r <= '0;
		end else begin
			flags_r <= (flags_r & ~clr_mask) | set_evt;
		end
	end

	assign irq_out = |(flags_r & mask_r);

	// Read data, one cycle after the strobe
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_CFG:      reg_rdata_out <= 32'(cfg_r);
				REG_OFFSET:   reg_rdata_out <= 32'(offset_r);
				REG_GAIN:     reg_rdata_out <= 32'(gain_r);
				REG_DATA:     reg_rdata_out <= 32'(result_r);
				REG_FLAG:     reg_rdata_out <= 32'(flags_r);
				REG_MASK:     reg_rdata_out <= 32'(mask_r);
				REG_DMA_CTRL: reg_rdata_out <= 32'({wrap_r, state_r == DMA_RUN});
				REG_DMA_BEG:  reg_rdata_out <= 32'(beg_r);
				REG_DMA_SIZE: reg_rdata_out <= 32'(size_r);
				REG_DMA_CUR:  reg_rdata_out <= 32'(cur_r);
				default:      reg_rdata_out <= '0;
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// Checks on correction, flags and DMA sequencing
	property p_reset_values;
		$rose(rst_b_in) |-> offset_r == OFFSET_RST && gain_r == GAIN_RST;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("offset or gain not at reset value");

	property p_unity_result;
		conv_done_in && offset_r == 16'h0000 && gain_r == 16'h8000
		|=> result_r == {$past(conv_raw_in[15]), $past(conv_raw_in[15:1])};
	endproperty
	a_unity_result: assert property (p_unity_result)
		else $error("unity correction did not halve raw value");

	property p_offset_add;
		conv_done_in && offset_r == 16'h0002 && gain_r == 16'h8000
		&& conv_raw_in == 16'h0000 |=> result_r == 16'h0001;
	endproperty
	a_offset_add: assert property (p_offset_add)
		else $error("offset not added before gain");

	property p_saturate;
		conv_done_in && offset_r == 16'h0000 && gain_r == 16'hffff
		&& conv_raw_in == 16'h7fff
		|=> flags_r[FLAG_SATURATE] && result_r == 16'h3fff;
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("positive overflow not clamped and flagged");

	property p_data_flag;
		conv_done_in |=> flags_r[FLAG_DATA];
	endproperty
	a_data_flag: assert property (p_data_flag)
		else $error("result ready flag not set");

	property p_w1c;
		reg_wr_in && reg_addr_in == REG_FLAG && reg_wdata_in[FLAG_DATA]
		&& !conv_done_in |=> !flags_r[FLAG_DATA];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear flag");

	property p_irq_gate;
		irq_out |-> (flags_r & mask_r) != '0;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt raised by a masked flag");

	property p_ptr_step;
		wr_done && !last_sample && !reset_wr && !load_wr
		|=> cur_r == $past(cur_r) + 16'h0002;
	endproperty
	a_ptr_step: assert property (p_ptr_step)
		else $error("pointer did not advance by two");

	property p_linear_stop;
		wr_done && last_sample && !wrap_r && !reset_wr && !load_wr
		|=> state_r == DMA_DONE && flags_r[FLAG_FULL] ##1 !ram_req_out;
	endproperty
	a_linear_stop: assert property (p_linear_stop)
		else $error("linear buffer did not stop when full");

	property p_wrap_reload;
		wr_done && last_sample && wrap_r && !reset_wr && !load_wr
		|=> state_r == DMA_RUN && cur_r == beg_r;
	endproperty
	a_wrap_reload: assert property (p_wrap_reload)
		else $error("wrap mode did not reload start pointer");

	property p_overrun;
		state_r == DMA_DONE && conv_done_in |=> flags_r[FLAG_OVERRUN];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged after full buffer");

	property p_idle_quiet;
		state_r == DMA_IDLE |-> !ram_req_out;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("transfer before load");

	property p_vref;
		vref_drive_out |-> conv_enable_out
		&& pin_config_fields_in[REF_PIN] == PIN_ANALOG;
	endproperty
	a_vref: assert property (p_vref)
		else $error("reference driven while unsafe");

	property p_analog_pin;
		pin_config_fields_in[0] == PIN_ANALOG
		|-> port_input_value_out[0] && !pin_digital_en_out[0];
	endproperty
	a_analog_pin: assert property (p_analog_pin)
		else $error("analog pin not isolated");

endmodule

/* verif/acdc_ram_model.sv */
// Behavioural RAM on the far side of the sample DMA channel
`timescale 1ns/1ps
module acdc_ram_model (
	input  wire logic                 sys_clk_in,
	input  wire logic                 rst_b_in,
	input  wire acdc_pkg::acdc_ram_wr_t ram_wr_in,
	input  wire logic                 ram_req_in,
	output logic                      ram_ready_out
);
	import acdc_pkg::*;
	logic [15:0] mem [0:32767];
	logic [1:0]  wait_r;
	logic        slow_r;
	int          wr_cnt;
	// Accept after a stall that alternates between none and two cycles
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			wait_r        <= 2'h0;
			slow_r        <= 1'b0;
			ram_ready_out <= 1'b0;
			wr_cnt        <= 0;
		end else if (ram_req_in && ram_ready_out) begin
			mem[ram_wr_in.addr[15:1]] <= ram_wr_in.data; // one half-word
			wr_cnt        <= wr_cnt + 1;
			ram_ready_out <= 1'b0;
			slow_r        <= ~slow_r;
			wait_r        <= 2'h0;
		end else if (ram_req_in && wait_r == (slow_r ? 2'h2 : 2'h0)) begin
			ram_ready_out <= 1'b1;
		end else if (ram_req_in) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule

/* verif/acdc_top_bench.sv */
// Self-checking bench for the correction and sample DMA block
`timescale 1ns/1ps
module acdc_top_bench;
	import acdc_pkg::*;
	logic            sys_clk_in = 1'b0;
	logic            rst_b_in = 1'b0;
	logic [7:0]      reg_addr_in = 8'h00;
	logic [31:0]     reg_wdata_in = 32'h0;
	logic            reg_wr_in = 1'b0;
	logic            reg_rd_in = 1'b0;
	logic            conv_done_in = 1'b0;
	logic [15:0]     conv_raw_in = 16'h0;
	logic [6:0][3:0] pin_config_fields_in = 28'h1111111;
	logic [6:0]      pin_raw_in = 7'h00;
	logic [31:0]     reg_rdata_out, rd_v;
	logic            conv_enable_out, vref_drive_out, ram_req_out, ram_ready_in, irq_out;
	logic [11:0]     pos_source_out, neg_source_out, exp_src;
	logic [6:0]      port_input_value_out, pin_digital_en_out;
	acdc_ram_wr_t    ram_wr_out;
	int              error_cnt = 0;
	int              samples_checked = 0;

	// Clock generator
	always #4 sys_clk_in = ~sys_clk_in;

	acdc_top DUT (.sys_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .conv_done_in, .conv_raw_in, .conv_enable_out,
		.pos_source_out, .neg_source_out, .vref_drive_out, .pin_config_fields_in,
		.pin_raw_in, .port_input_value_out, .pin_digital_en_out, .ram_wr_out,
		.ram_req_out, .ram_ready_in, .irq_out);
	acdc_ram_model ram (.sys_clk_in, .rst_b_in, .ram_wr_in(ram_wr_out),
		.ram_req_in(ram_req_out), .ram_ready_out(ram_ready_in));

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Register bus write and read cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
		#1;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1 rd_v = reg_rdata_out;
		chk(rd_v & m, e);
	endtask

	// One conversion, then wait until any DMA write has been accepted
	task automatic conv(input logic [15:0] raw);
		int n;
		@(posedge sys_clk_in);
		conv_done_in <= 1'b1;
		conv_raw_in  <= raw;
		@(posedge sys_clk_in);
		conv_done_in <= 1'b0;
		@(posedge sys_clk_in);
		#1 n = 0;
		while (ram_req_out !== 1'b0 && n < 20) begin
			@(posedge sys_clk_in);
			#1 n++;
		end
		if (n == 20) begin
			error_cnt++;
			finish_test();
		end
	endtask

	task automatic t_reset();
		rchk(REG_OFFSET, 32'hffff, 32'h0000);
		rchk(REG_GAIN, 32'hffff, 32'h8000);
		rchk(8'h40, 32'hffffffff, 32'h0);
	endtask

	task automatic t_corr();
		wr(REG_CFG, 32'h901);
		chk(32'(conv_enable_out), 32'h1);
		wr(REG_OFFSET, 32'h0010);
		conv(16'h0100);
		rchk(REG_DATA, 32'hffff, 32'h0088);
		wr(REG_OFFSET, 32'h0);
		wr(REG_GAIN, 32'hc000);
		conv(16'hff00);
		rchk(REG_DATA, 32'hffff, 32'hff40);
		wr(REG_OFFSET, 32'h0002);
		wr(REG_GAIN, 32'h8000);
		conv(16'h0000);
		rchk(REG_DATA, 32'hffff, 32'h0001);
		wr(REG_OFFSET, 32'h0);
		wr(REG_GAIN, 32'hffff);
		conv(16'h7fff);
		rchk(REG_DATA, 32'hffff, 32'h3fff);
		conv(16'h8000);
		rchk(REG_DATA, 32'hffff, 32'hc000);
		wr(REG_FLAG, 32'h1f);
		conv(16'h7000);
		rchk(REG_DATA, 32'hffff, 32'h3fff);
		rchk(REG_FLAG, 32'h12, 32'h12);
	endtask

	task automatic t_flags();
		wr(REG_FLAG, 32'h0);
		rchk(REG_FLAG, 32'h12, 32'h12);
		wr(REG_MASK, 32'h0);
		chk(32'(irq_out), 32'h0);
		wr(REG_MASK, 32'h2);
		chk(32'(irq_out), 32'h1);
		wr(REG_FLAG, 32'h2);
		rchk(REG_FLAG, 32'h12, 32'h10);
		chk(32'(irq_out), 32'h0);
	endtask

	task automatic t_mux();
		for (int c = 0; c < 16; c++) begin
			wr(REG_CFG, {20'h0, 4'h9, c[3:0], 4'h1});
			exp_src = (c <= 5) ? 12'h1 << c : (c >= 8 && c <= 11) ? 12'h1 << (c - 2) : 12'h0;
			chk({20'h0, pos_source_out}, {20'h0, exp_src});
			chk({20'h0, neg_source_out}, 32'h080);
		end
	endtask

	task automatic t_pins();
		@(posedge sys_clk_in);
		pin_config_fields_in <= 28'h0111011;
		pin_raw_in           <= 7'h11;
		wr(REG_CFG, 32'h903);
		chk({25'h0, port_input_value_out}, 32'h55);
		chk({25'h0, pin_digital_en_out}, 32'h3b);
		chk(32'(vref_drive_out), 32'h1);
		@(posedge sys_clk_in);
		pin_config_fields_in <= 28'h1111111;
		@(posedge sys_clk_in);
		#1 chk(32'(vref_drive_out), 32'h0);
		chk({25'h0, port_input_value_out}, 32'h11);
		@(posedge sys_clk_in);
		pin_config_fields_in <= 28'h0111011;
		wr(REG_CFG, 32'h902);
		chk(32'(vref_drive_out), 32'h0);
	endtask

	task automatic t_linear();
		wr(REG_CFG, 32'h901);
		wr(REG_GAIN, 32'h8000);
		wr(REG_DMA_CTRL, 32'h10);
		wr(REG_DMA_BEG, 32'h0100);
		wr(REG_DMA_SIZE, 32'h4);
		conv(16'h0030);
		chk(32'(ram.wr_cnt), 32'h0);
		wr(REG_FLAG, 32'h1f);
		wr(REG_DMA_CTRL, 32'h1);
		for (int i = 1; i <= 4; i++) begin
			conv(16'h0010 * i);
			if (i == 1) rchk(REG_DMA_CUR, 32'hffff, 32'h0102);
			if (i == 2) rchk(REG_FLAG, 32'h0c, 32'h08);
		end
		rchk(REG_FLAG, 32'h0d, 32'h0c);
		for (int i = 0; i < 4; i++)
			chk({16'h0, ram.mem[16'h80 + i]}, 32'h0008 * (i + 1));
		conv(16'h0050);
		chk(32'(ram.wr_cnt), 32'h4);
		rchk(REG_FLAG, 32'h01, 32'h01);
	endtask

	task automatic t_wrap();
		wr(REG_DMA_CTRL, 32'h10);
		wr(REG_DMA_BEG, 32'h0200);
		wr(REG_DMA_SIZE, 32'h2);
		wr(REG_FLAG, 32'h1f);
		wr(REG_DMA_CTRL, 32'h3);
		rchk(REG_DMA_CTRL, 32'h3, 32'h3);
		conv(16'h0100);
		conv(16'h0200);
		conv(16'h0300);
		chk({16'h0, ram.mem[16'h100]}, 32'h0180);
		chk({16'h0, ram.mem[16'h101]}, 32'h0100);
		chk(32'(ram.wr_cnt), 32'h7);
		rchk(REG_FLAG, 32'h01, 32'h00);
	endtask

	// Main sequence
	initial begin
		repeat (3) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_corr();
		t_flags();
		t_mux();
		t_pins();
		t_linear();
		t_wrap();
		finish_test();
	end

	// Hang guard
	initial begin
		#400000;
		error_cnt++;
		finish_test();
	end
endmodule
